/* src/hsc_params.svh */
// Command codes, field positions, reset values and timing of the hot-swap command logic
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH
`define HSC_CMD_OPERATION   8'h01
`define HSC_CMD_CLEAR       8'h03
`define HSC_CMD_CAPABILITY  8'h19
`define HSC_CMD_STATUS_BYTE 8'h78
`define HSC_CMD_STATUS_WORD 8'h79
`define HSC_CMD_STATUS_VOUT 8'h7A
`define HSC_CMD_STATUS_IOUT 8'h7B
`define HSC_CMD_STATUS_IN   8'h7C
`define HSC_CMD_STATUS_MFR  8'h80
`define HSC_CMD_REVISION    8'h98
`define HSC_CMD_MFR_ID      8'h99
`define HSC_CMD_MFR_MODEL   8'h9A
`define HSC_CMD_MFR_REV     8'h9B
`define HSC_CMD_DEV_CFG     8'hD0
`define HSC_CMD_POWER_CYCLE 8'hD1
`define HSC_CMD_PIN1_ALERT  8'hD2
`define HSC_CMD_PIN2_ALERT  8'hD3
`define HSC_OP_ON_BIT       7
`define HSC_CFG_FOLDBACK    0
`define HSC_CFG_GLITCH_LO   1
`define HSC_CFG_WARN2_POL   3
`define HSC_CFG_OP_EN       4
`define HSC_ALR_GPO_MODE    12
`define HSC_ALR_GPO_VAL     13
`define HSC_ALR_SAMPLE_TRIGGER_MODE   14
`define HSC_OP_RESET        8'h80
`define HSC_CFG_RESET       16'h0000
`define HSC_ALR_RESET       16'h0000
`define HSC_CAPABILITY_VAL  8'hB0
`define HSC_REVISION_VAL    8'h11
// Identity strings are arbitrary
`define HSC_MFR_ID_STR      64'h0000000056454E44
`define HSC_MFR_ID_LEN      4'h4
`define HSC_MFR_MODEL_STR   64'h0000004853433031
`define HSC_MFR_MODEL_LEN   4'h5
`define HSC_MFR_REV_STR     64'h0000000000004130
`define HSC_MFR_REV_LEN     4'h2
`define HSC_PCYCLE_S        4
`define HSC_CLK_HZ          10000000
`endif

/* src/hsc_pkg.sv */
// Types shared by the hot-swap command logic
`default_nettype none
package hsc_pkg;
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] data;
    } hsc_cmd_t;

    typedef struct packed {
        logic vin_ov;
        logic vin_uv;
        logic vout_ov;
        logic vout_uv;
        logic iout_oc;
        logic iout_w2;
    } hsc_warn_t;

    typedef struct packed {
        logic      cml;
        logic      ov;
        logic      uv;
        logic      oc;
        hsc_warn_t warn;
    } hsc_flt_t;

    typedef enum logic [1:0] {
        HSC_PC_IDLE = 2'b01,
        HSC_PC_OFF  = 2'b10
    } hsc_pc_t;

    typedef struct packed {
        logic [2:0]       uv_sy;
        logic [2:0]       ov_sy;
        logic [2:0]       cv_sy;
        logic             uv_ok;
        logic             ov_hi;
        logic             cv_lvl;
        logic [7:0]       op;
        logic             clr_armed;
        logic [15:0]      cfg;
        logic [1:0][15:0] acfg;
        hsc_flt_t         flt;
        hsc_cmd_t         pend;
        logic             pend_v;
        hsc_pc_t          pc;
        logic [31:0]      pc_cnt;
        logic [7:0]       last_rd;
        logic [3:0]       blk_idx;
        logic             fet;
        logic [1:0]       p_oe;
        logic             trig;
        logic             nack;
        logic [15:0]      rdata;
    } hsc_state_t;
endpackage
`default_nettype wire

/* src/hsc_cmd_status.sv */
// Command and status logic of the hot-swap controller
//
// Behaviour
// - Gate drive stays off while undervoltage input shows insufficient supply.
// - Operation set off forces gate drive low whatever the analog side permits.
// - On bit resets to one, so permit, undervoltage and overvoltage inputs control output.
// - Operation writes are refused with nack until config permit bit is set.
// - On bit to zero turns output off; no effect while already off.
// - On bit to one requests turn-on; blocked by undervoltage or overvoltage.
// - Writing on bit zero then one clears all latched fault bits.
// - Status byte and word show whether the output is enabled.
// - Config command holds foldback, glitch filter length, second warning polarity.
// - Power cycle command turns output off about four seconds, then back on.
// - Capability read reports bus speed, error checking and alert support.
// - Identity commands answer block reads: byte count first, then ASCII.
// - Six status registers; byte and word summaries point at four details.
// - Faults come only from overcurrent timeout, overvoltage or undervoltage pins.
// - Warnings come from monitor limits only and never touch the gate.
// - Fault and warning bits latch until cleared; some bits are live.
// - Status word low byte equals status byte; high byte holds pointers.
// - Clear faults clears ended conditions; active ones set again at once.
// - Each multipurpose pin is general output or alert output independently.
// - Alert masks choose source bits and are ignored in output mode.
// - First pin may be sample trigger input; then its masks are ignored.
// - Write with bad error check byte is not executed and sets a flag.
// - Group command writes wait for the bus stop before executing.
`default_nettype none
`include "hsc_params.svh"
module hsc_cmd_status #(
    parameter int unsigned PCYCLE_S      = `HSC_PCYCLE_S,
    parameter int unsigned CLK_HZ        = `HSC_CLK_HZ,
    parameter int unsigned PCYCLE_CYCLES = PCYCLE_S * CLK_HZ
) (
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [7:0]        addr,
    input  wire logic [15:0]       wdata,
    input  wire logic              wr_strobe,
    input  wire logic              rd_strobe,
    input  wire logic              wr_pec_bad,
    input  wire logic              wr_group,
    input  wire logic              bus_stop,
    output logic      [15:0]       rdata,
    output logic                   wr_nack,
    input  wire logic              undervoltage_input,
    input  wire logic              high_supply_input,
    input  wire logic              hs_permit,
    input  wire logic              oc_timeout,
    input  wire hsc_pkg::hsc_warn_t warn_in,
    output logic                   fet_drive_en,
    output logic                   foldback_en,
    output logic      [1:0]        glitch_sel,
    output logic                   warn2_under,
    input  wire logic              multi_pin_one_in,
    output logic                   multi_pin_one_out,
    output logic                   multi_pin_one_oe,
    output logic                   multi_pin_two_out,
    output logic                   multi_pin_two_oe,
    output logic                   sample_trigger
);
    localparam logic [31:0] PC_LAST = 32'(PCYCLE_CYCLES - 1);

    hsc_pkg::hsc_state_t s;
    hsc_pkg::hsc_state_t next_s;

    function automatic logic [7:0] str_byte(input logic [63:0] str,
                                            input logic [3:0]  len,
                                            input logic [3:0]  idx);
        logic [3:0] pos;
        pos = len - idx;
        str_byte = 8'(str >> {pos, 3'b000});
    endfunction

    hsc_pkg::hsc_cmd_t ex;
    logic              ex_v;
    logic              op_lock;
    logic              clear_req;
    logic              pc_start;
    logic [9:0]        cond;
    logic [7:0]        sbyte;
    logic [7:0]        s_in;
    logic [7:0]        s_vout;
    logic [7:0]        s_iout;
    logic [7:0]        s_mfr;
    logic [15:0]       sword;
    logic [3:0]        idx;
    logic              cv_rise;

    always_comb begin
        next_s = s;
        // Three-stage filters; a level counts once stages two and three agree
        next_s.uv_sy = {s.uv_sy[1:0], undervoltage_input};
        next_s.ov_sy = {s.ov_sy[1:0], high_supply_input};
        next_s.cv_sy = {s.cv_sy[1:0], multi_pin_one_in};
        if (s.uv_sy[1] == s.uv_sy[2]) begin
            next_s.uv_ok = s.uv_sy[2];
        end
        if (s.ov_sy[1] == s.ov_sy[2]) begin
            next_s.ov_hi = s.ov_sy[2];
        end

        cv_rise = 1'b0;
        if (s.cv_sy[1] == s.cv_sy[2]) begin
            next_s.cv_lvl = s.cv_sy[2];
            cv_rise = s.cv_sy[2] & ~s.cv_lvl;
        end

        ex = '{addr: addr, data: wdata};
        ex_v = wr_strobe & ~wr_pec_bad & ~wr_group;
        if (wr_strobe & ~wr_pec_bad & wr_group) begin
            next_s.pend = '{addr: addr, data: wdata};
            next_s.pend_v = 1'b1;
        end
        // A pending write has priority at stop; a plain write in that cycle is dropped
        if (bus_stop & s.pend_v) begin
            ex = s.pend;
            ex_v = 1'b1;
            next_s.pend_v = 1'b0;
        end

        op_lock = ~s.cfg[`HSC_CFG_OP_EN];
        next_s.nack = wr_strobe & ~wr_pec_bad & (addr == `HSC_CMD_OPERATION) & op_lock;

        clear_req = 1'b0;
        pc_start = 1'b0;
        if (ex_v) begin
            case (ex.addr)
                `HSC_CMD_OPERATION: begin
                    if (!op_lock) begin
                        next_s.op = ex.data[7:0];
                        // off then on clears latched faults
                        if (!ex.data[`HSC_OP_ON_BIT]) begin
                            next_s.clr_armed = 1'b1;
                        end else if (s.clr_armed) begin
                            clear_req = 1'b1;
                            next_s.clr_armed = 1'b0;
                        end
                    end
                end
                `HSC_CMD_CLEAR: clear_req = 1'b1;
                `HSC_CMD_DEV_CFG: next_s.cfg = ex.data;
                `HSC_CMD_POWER_CYCLE: pc_start = 1'b1;
                `HSC_CMD_PIN1_ALERT: next_s.acfg[0] = ex.data;
                `HSC_CMD_PIN2_ALERT: next_s.acfg[1] = ex.data;
                default: ;
            endcase
        end

        // fault sources; bad check byte flag
        cond = {wr_strobe & wr_pec_bad, s.ov_hi, ~s.uv_ok, oc_timeout, warn_in};
        // latch; still-active condition wins over clear
        next_s.flt = hsc_pkg::hsc_flt_t'((clear_req ? 10'h000 : 10'(s.flt)) | cond);

        case (s.pc)
            hsc_pkg::HSC_PC_IDLE: begin
                if (pc_start) begin
                    next_s.pc = hsc_pkg::HSC_PC_OFF;
                    next_s.pc_cnt = PC_LAST;
                end
            end
            hsc_pkg::HSC_PC_OFF: begin
                if (s.pc_cnt == 32'h00000000) begin
                    next_s.pc = hsc_pkg::HSC_PC_IDLE;
                end else begin
                    next_s.pc_cnt = s.pc_cnt - 32'h00000001;
                end
            end
            default: next_s.pc = hsc_pkg::HSC_PC_IDLE;
        endcase

        next_s.fet = hs_permit & s.uv_ok & ~s.ov_hi & s.op[`HSC_OP_ON_BIT]
                   & (s.pc == hsc_pkg::HSC_PC_IDLE);

        // detail registers and summaries; off bit
        s_in   = {s.flt.ov, 1'b0, s.flt.warn.vin_ov, s.flt.warn.vin_uv,
                  s.flt.uv, 3'b000};
        s_vout = {1'b0, s.flt.warn.vout_ov, 2'b00, s.flt.warn.vout_uv, 3'b000};
        s_iout = {s.flt.oc, 1'b0, s.flt.warn.iout_oc, 4'h0, s.flt.warn.iout_w2};

        // Live bits: power cycle running, trigger pin level
        s_mfr  = {6'h00, s.pc == hsc_pkg::HSC_PC_OFF, s.cv_lvl};
        sbyte  = {1'b0, ~s.fet, 1'b0, s.flt.oc, s.flt.uv, 1'b0, s.flt.cml,
                  s.flt.ov | (|s.flt.warn)};

        sword  = {s_vout != 8'h00, s_iout != 8'h00, s_in != 8'h00,
                  s_mfr != 8'h00, 4'h0, sbyte};

        // Read port: data only in the cycle after the strobe
        next_s.rdata = 16'h0000;
        idx = 4'h0;
        if (rd_strobe) begin
            next_s.last_rd = addr;
            next_s.blk_idx = 4'h0;
            idx = (addr == s.last_rd) ? s.blk_idx : 4'h0;
            case (addr)
                `HSC_CMD_OPERATION:   next_s.rdata = {8'h00, s.op};
                `HSC_CMD_CAPABILITY:  next_s.rdata = {8'h00, `HSC_CAPABILITY_VAL};
                `HSC_CMD_STATUS_BYTE: next_s.rdata = {8'h00, sbyte};
                `HSC_CMD_STATUS_WORD: next_s.rdata = sword;
                `HSC_CMD_STATUS_VOUT: next_s.rdata = {8'h00, s_vout};
                `HSC_CMD_STATUS_IOUT: next_s.rdata = {8'h00, s_iout};
                `HSC_CMD_STATUS_IN:   next_s.rdata = {8'h00, s_in};
                `HSC_CMD_STATUS_MFR:  next_s.rdata = {8'h00, s_mfr};
                `HSC_CMD_REVISION:    next_s.rdata = {8'h00, `HSC_REVISION_VAL};
                `HSC_CMD_DEV_CFG:     next_s.rdata = s.cfg;
                `HSC_CMD_PIN1_ALERT:  next_s.rdata = s.acfg[0];
                `HSC_CMD_PIN2_ALERT:  next_s.rdata = s.acfg[1];
                // block reads step count, then characters
                `HSC_CMD_MFR_ID: begin
                    next_s.rdata = {8'h00, (idx == 4'h0) ? {4'h0, `HSC_MFR_ID_LEN} :
                        (idx > `HSC_MFR_ID_LEN) ? 8'h00 :
                        str_byte(`HSC_MFR_ID_STR, `HSC_MFR_ID_LEN, idx)};
                    next_s.blk_idx = idx + 4'h1;
                end
                `HSC_CMD_MFR_MODEL: begin
                    next_s.rdata = {8'h00, (idx == 4'h0) ? {4'h0, `HSC_MFR_MODEL_LEN} :
                        (idx > `HSC_MFR_MODEL_LEN) ? 8'h00 :
                        str_byte(`HSC_MFR_MODEL_STR, `HSC_MFR_MODEL_LEN, idx)};
                    next_s.blk_idx = idx + 4'h1;
                end
                `HSC_CMD_MFR_REV: begin
                    next_s.rdata = {8'h00, (idx == 4'h0) ? {4'h0, `HSC_MFR_REV_LEN} :
                        (idx > `HSC_MFR_REV_LEN) ? 8'h00 :
                        str_byte(`HSC_MFR_REV_STR, `HSC_MFR_REV_LEN, idx)};
                    next_s.blk_idx = idx + 4'h1;
                end
                default: next_s.rdata = 16'h0000;
            endcase
        end

        // pin modes, open drain, low means asserted
        for (int p = 0; p < 2; p++) begin
            if (p == 0 && s.acfg[p][`HSC_ALR_SAMPLE_TRIGGER_MODE]) begin
                next_s.p_oe[p] = 1'b0;
            end else if (s.acfg[p][`HSC_ALR_GPO_MODE]) begin
                next_s.p_oe[p] = ~s.acfg[p][`HSC_ALR_GPO_VAL];
            end else begin
                next_s.p_oe[p] = |(10'(s.flt) & s.acfg[p][9:0]);
            end
        end

        next_s.trig = s.acfg[0][`HSC_ALR_SAMPLE_TRIGGER_MODE] & cv_rise;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s         <= '0;
            s.op      <= `HSC_OP_RESET;
            s.cfg     <= `HSC_CFG_RESET;
            s.acfg[0] <= `HSC_ALR_RESET;
            s.acfg[1] <= `HSC_ALR_RESET;
            s.pc      <= hsc_pkg::HSC_PC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rdata             = s.rdata;
    assign wr_nack           = s.nack;
    assign fet_drive_en      = s.fet;

    assign foldback_en       = s.cfg[`HSC_CFG_FOLDBACK];
    assign glitch_sel        = s.cfg[`HSC_CFG_GLITCH_LO +: 2];
    assign warn2_under       = s.cfg[`HSC_CFG_WARN2_POL];
    assign multi_pin_one_out = 1'b0;
    assign multi_pin_one_oe  = s.p_oe[0];
    assign multi_pin_two_out = 1'b0;
    assign multi_pin_two_oe  = s.p_oe[1];
    assign sample_trigger    = s.trig;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence op_write(logic v);
        wr_strobe && !wr_pec_bad && !wr_group && !bus_stop && addr == `HSC_CMD_OPERATION
            && s.cfg[`HSC_CFG_OP_EN] && wdata[`HSC_OP_ON_BIT] == v;
    endsequence

    // Off, one quiet cycle, on; no new overcurrent
    sequence op_off_on;
        op_write(1'b0) ##1 (!wr_strobe && !bus_stop) ##1 op_write(1'b1) ##0 !oc_timeout;
    endsequence

    // Gate drive
    a_fet_uv_block: assert property (!s.uv_ok |=> !fet_drive_en)
        else $error("gate on during undervoltage");

    a_fet_op_off: assert property (!s.op[`HSC_OP_ON_BIT] |=> !fet_drive_en)
        else $error("gate on while operation off");

    a_fet_turn_on: assert property (hs_permit && s.uv_ok && !s.ov_hi
        && s.op[`HSC_OP_ON_BIT] && s.pc == hsc_pkg::HSC_PC_IDLE |=> fet_drive_en)
        else $error("gate not enabled when permitted");

    // Command port
    a_op_nack: assert property (wr_strobe && !wr_pec_bad
        && addr == `HSC_CMD_OPERATION && !s.cfg[`HSC_CFG_OP_EN]
        |=> wr_nack && $stable(s.op))
        else $error("locked operation write not refused");

    // Nack answers only an operation write
    a_nack_only: assert property (!(wr_strobe && addr == `HSC_CMD_OPERATION)
        |=> !wr_nack)
        else $error("stray nack");

    a_clear_cycle: assert property (op_off_on |=> !s.flt.oc && !s.flt.cml)
        else $error("off-on sequence left faults");

    // Status and faults
    a_word_low: assert property (rd_strobe && addr == `HSC_CMD_STATUS_WORD
        |=> rdata[7:0] == $past(sbyte) && rdata[14] == ($past(s_iout) != 8'h00))
        else $error("status word low byte mismatch");

    a_status_off: assert property (rd_strobe && addr == `HSC_CMD_STATUS_BYTE
        |=> rdata[6] == !$past(fet_drive_en))
        else $error("off bit wrong");

    a_fault_hold: assert property (s.flt.oc && !clear_req |=> s.flt.oc)
        else $error("latched fault dropped");

    // Set wins over a clear in one cycle
    a_fault_set: assert property (oc_timeout
        |=> s.flt.oc)
        else $error("overcurrent not latched");

    a_uv_fault: assert property (!s.uv_ok
        |=> s.flt.uv)
        else $error("undervoltage not latched");

    a_ov_fault: assert property (s.ov_hi
        |=> s.flt.ov)
        else $error("overvoltage not latched");

    a_clear_live: assert property (clear_req && !s.uv_ok |=> s.flt.uv)
        else $error("active fault not set again");

    // Gate drops a cycle after the count loads
    a_pcycle_off: assert property ($rose(s.pc == hsc_pkg::HSC_PC_OFF)
        |=> !fet_drive_en [*2] ##0 s.pc_cnt == PC_LAST - 32'h00000002)
        else $error("power cycle did not hold output off");

    a_pec_drop: assert property (wr_strobe && wr_pec_bad
        |=> s.flt.cml && $stable(s.cfg) && !wr_nack)
        else $error("bad check byte write executed");

    a_group_defer: assert property (wr_strobe && wr_group && !wr_pec_bad
        && !bus_stop |=> $stable(s.cfg) && $stable(s.op) && s.pend_v)
        else $error("group write executed before stop");

    // Pins
    a_gpo_mode: assert property (s.acfg[1][`HSC_ALR_GPO_MODE]
        |=> multi_pin_two_oe == !$past(s.acfg[1][`HSC_ALR_GPO_VAL]))
        else $error("general output mode wrong");

    a_sample_trigger_mode: assert property (s.acfg[0][`HSC_ALR_SAMPLE_TRIGGER_MODE]
        |=> !multi_pin_one_oe)
        else $error("trigger pin driven");

    // A new rise needs the level low first
    a_trig_pulse: assert property (sample_trigger
        |=> !sample_trigger)
        else $error("trigger pulse too long");
endmodule
`default_nettype wire

/* verification/hsc_host_model.sv */
// Host side model: bus master of the command port
`default_nettype none
module hsc_host_model (
    input  wire logic        clk,
    output logic      [7:0]  addr,
    output logic      [15:0] wdata,
    output logic             wr_strobe,
    output logic             rd_strobe,
    output logic             wr_pec_bad,
    output logic             wr_group,
    output logic             bus_stop,
    input  wire logic [15:0] rdata,
    input  wire logic        wr_nack
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        wr_pec_bad = 1'b0;
        wr_group = 1'b0;
        bus_stop = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic pec,
                      input logic grp, output logic nack);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_pec_bad <= pec;
        wr_group <= grp;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
        wr_pec_bad <= 1'b0;
        wr_group <= 1'b0;
        // Released lines show the inverse so stale values never match
        addr <= ~a;
        wdata <= ~d;
        #1;
        nack = wr_nack;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask
    task automatic stop();
        @(posedge clk);
        bus_stop <= 1'b1;
        @(posedge clk);
        bus_stop <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* verification/hsc_cmd_status_tb.sv */
// Self-checking bench of the hot-swap command and status logic
`default_nettype none
`include "hsc_params.svh"
module hsc_cmd_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned PCYC = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, rd;
    logic wr_strobe, rd_strobe, wr_pec_bad, wr_group, bus_stop, wr_nack, nk;
    logic uvi = 1'b0, ovi = 1'b0, permit = 1'b0, oct = 1'b0, p1in = 1'b0, link_on = 1'b0;
    hsc_pkg::hsc_warn_t warn = '0;
    logic fet, fold, w2u, p1out, p1oe, p2out, p2oe, strig;
    logic [1:0] glitch, lk = 2'b00;
    int fails = 0, checks_done = 0, trig_n = 0, t0, n;
    always #50 clk = ~clk;
    hsc_host_model hsc_host_model_inst (.clk(clk), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .wr_pec_bad(wr_pec_bad),
        .wr_group(wr_group), .bus_stop(bus_stop), .rdata(rdata), .wr_nack(wr_nack));
    hsc_cmd_status #(.PCYCLE_CYCLES(PCYC)) hsc_cmd_status_inst (.clk(clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .wr_pec_bad(wr_pec_bad), .wr_group(wr_group), .bus_stop(bus_stop), .rdata(rdata),
        .wr_nack(wr_nack), .undervoltage_input(uvi), .high_supply_input(ovi),
        .hs_permit(permit), .oc_timeout(oct), .warn_in(warn), .fet_drive_en(fet),
        .foldback_en(fold), .glitch_sel(glitch), .warn2_under(w2u),
        .multi_pin_one_in(p1in), .multi_pin_one_out(p1out), .multi_pin_one_oe(p1oe),
        .multi_pin_two_out(p2out), .multi_pin_two_oe(p2oe), .sample_trigger(strig));
    // Pin one as an 800 ns link clock, running only inside a burst
    always @(posedge clk) begin
        if (link_on) begin
            lk <= lk + 2'd1;
            if (lk == 2'b11) p1in <= ~p1in;
        end
        if (strig === 1'b1) trig_n <= trig_n + 1;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wf(input logic v, input int k);
        for (n = 0; n < k && fet !== v; n++) cyc(1);
        chk("fet_drive_en", v, fet);
        if (fet !== v) finish_test();
    endtask
    task automatic w(input logic [7:0] a, input logic [15:0] d);
        hsc_host_model_inst.wr(a, d, 1'b0, 1'b0, nk);
    endtask
    task automatic r(input logic [7:0] a, input logic [15:0] exp);
        hsc_host_model_inst.rd(a, rd);
        chk($sformatf("read of %h", a), exp, rd);
    endtask
    task automatic pulse_oc();
        @(posedge clk);
        oct <= 1'b1;
        @(posedge clk);
        oct <= 1'b0;
        cyc(2);
    endtask
    task automatic blk(input logic [7:0] a, input logic [63:0] s, input logic [3:0] len);
        int i;
        r(a, {12'h000, len});
        for (i = 0; i < len; i++) r(a, {8'h00, s[8*(len-1-i) +: 8]});
        r(a, 16'h0000);
    endtask
    task automatic t_supply();
        @(posedge clk);
        permit <= 1'b1;
        cyc(10);
        chk("fet_drive_en", 1'b0, fet); // no supply
        @(posedge clk);
        uvi <= 1'b1;
        wf(1'b1, 20); // on by default
        w(`HSC_CMD_CLEAR, 16'h0000);
        r(`HSC_CMD_STATUS_BYTE, 16'h0000); // output on
        r(`HSC_CMD_CAPABILITY, {8'h00, `HSC_CAPABILITY_VAL}); // capability
        r(`HSC_CMD_REVISION, {8'h00, `HSC_REVISION_VAL});
        $display("test supply done");
    endtask
    task automatic t_ops();
        w(`HSC_CMD_OPERATION, 16'h0000);
        chk("wr_nack", 1'b1, nk); // locked
        cyc(3);
        chk("fet_drive_en", 1'b1, fet); // unchanged
        w(`HSC_CMD_DEV_CFG, 16'h001F);
        chk("wr_nack", 1'b0, nk); // enabled
        cyc(1);
        chk("foldback_en", 1'b1, fold); // foldback
        chk("glitch_sel", 2'b11, glitch); // glitch
        chk("warn2_under", 1'b1, w2u); // polarity
        pulse_oc();
        r(`HSC_CMD_STATUS_BYTE, 16'h0010); // latched
        w(`HSC_CMD_OPERATION, 16'h0000);
        wf(1'b0, 5); // off
        r(`HSC_CMD_STATUS_BYTE, 16'h0050); // off shown
        w(`HSC_CMD_OPERATION, 16'h0080);
        wf(1'b1, 5); // back on
        r(`HSC_CMD_STATUS_BYTE, 16'h0000); // faults cleared
        pulse_oc();
        w(`HSC_CMD_OPERATION, 16'h0000);
        w(`HSC_CMD_OPERATION, 16'h0080); // no gap
        r(`HSC_CMD_STATUS_BYTE, 16'h0000); // cleared
        $display("test operation done");
    endtask
    task automatic t_ov();
        @(posedge clk);
        ovi <= 1'b1;
        wf(1'b0, 10); // overvoltage
        w(`HSC_CMD_OPERATION, 16'h0080);
        cyc(5);
        chk("fet_drive_en", 1'b0, fet); // no effect
        r(`HSC_CMD_STATUS_IN, 16'h0080); // detail
        w(`HSC_CMD_CLEAR, 16'h0000);
        r(`HSC_CMD_STATUS_BYTE, 16'h0041); // still active
        @(posedge clk);
        ovi <= 1'b0;
        wf(1'b1, 10);
        w(`HSC_CMD_CLEAR, 16'h0000);
        r(`HSC_CMD_STATUS_BYTE, 16'h0000); // ended
        $display("test overvoltage done");
    endtask
    task automatic t_warn();
        @(posedge clk);
        warn.iout_oc <= 1'b1;
        @(posedge clk);
        warn <= '0;
        cyc(2);
        chk("fet_drive_en", 1'b1, fet); // no gate effect
        r(`HSC_CMD_STATUS_BYTE, 16'h0001); // warning
        r(`HSC_CMD_STATUS_WORD, 16'h4001); // word
        r(`HSC_CMD_STATUS_IOUT, 16'h0020); // detail
        w(`HSC_CMD_CLEAR, 16'h0000);
        r(`HSC_CMD_STATUS_WORD, 16'h0000); // cleared
        $display("test warning done");
    endtask
    task automatic t_bus();
        hsc_host_model_inst.wr(`HSC_CMD_OPERATION, 16'h0000, 1'b1, 1'b0, nk);
        cyc(4);
        chk("fet_drive_en", 1'b1, fet); // dropped
        r(`HSC_CMD_STATUS_BYTE, 16'h0002); // flag
        w(`HSC_CMD_CLEAR, 16'h0000);
        hsc_host_model_inst.wr(`HSC_CMD_OPERATION, 16'h0000, 1'b0, 1'b1, nk);
        cyc(4);
        chk("fet_drive_en", 1'b1, fet); // deferred
        hsc_host_model_inst.stop();
        wf(1'b0, 5); // runs at stop
        w(`HSC_CMD_OPERATION, 16'h0080);
        wf(1'b1, 5);
        w(`HSC_CMD_POWER_CYCLE, 16'h0000);
        wf(1'b0, 3);
        for (t0 = 1; t0 < 60 && fet === 1'b0; t0++) cyc(1);
        chk("power cycle off time", 1'b1, t0 >= PCYC && t0 <= PCYC + 3); // timed
        wf(1'b1, 1); // back on
        blk(`HSC_CMD_MFR_ID, `HSC_MFR_ID_STR, `HSC_MFR_ID_LEN); // id
        blk(`HSC_CMD_MFR_MODEL, `HSC_MFR_MODEL_STR, `HSC_MFR_MODEL_LEN); // model
        blk(`HSC_CMD_MFR_REV, `HSC_MFR_REV_STR, `HSC_MFR_REV_LEN); // revision
        $display("test bus done");
    endtask
    task automatic t_pins();
        pulse_oc();
        w(`HSC_CMD_PIN2_ALERT, 16'h1040);
        cyc(2);
        chk("multi_pin_two_oe", 1'b1, p2oe); // output low
        w(`HSC_CMD_PIN2_ALERT, 16'h3040);
        cyc(2);
        chk("multi_pin_two_oe", 1'b0, p2oe); // mask ignored
        w(`HSC_CMD_PIN2_ALERT, 16'h0040);
        cyc(2);
        chk("multi_pin_two_oe", 1'b1, p2oe); // alert
        chk("multi_pin_two_out", 1'b0, p2out);
        chk("multi_pin_one_out", 1'b0, p1out);
        w(`HSC_CMD_PIN1_ALERT, 16'h0040);
        cyc(2);
        chk("multi_pin_one_oe", 1'b1, p1oe); // independent
        w(`HSC_CMD_PIN1_ALERT, 16'h4040);
        cyc(2);
        chk("multi_pin_one_oe", 1'b0, p1oe); // masks ignored
        t0 = trig_n;
        @(posedge clk);
        link_on <= 1'b1;
        cyc(80);
        link_on <= 1'b0;
        cyc(10);
        chk("sample_trigger count", 16'd10, 16'(trig_n - t0)); // trigger
        w(`HSC_CMD_CLEAR, 16'h0000);
        cyc(2);
        chk("multi_pin_two_oe", 1'b0, p2oe); // alert released
        $display("test pins done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1;
        chk("fet_drive_en", 1'b0, fet); // reset
        chk("foldback_en", 1'b0, fold); // reset
        @(posedge clk);
        resetn <= 1'b1;
        t_supply();
        t_ops();
        t_ov();
        t_warn();
        t_bus();
        t_pins();
        finish_test();
    end
endmodule
`default_nettype wire
